//--- gla_defs.vh
/*
 * Shared constants for the gas level alarm evaluator: alarm type and
 * policy codes, timing counts, default thresholds and indicator codes.
 * Assumes readings and thresholds are signed 16-bit values in tenths of a
 * percent of sensor range (toxic) or tenths of a percent O2 (oxygen).
 */
`ifndef GLA_DEFS_VH
`define GLA_DEFS_VH

// Alarm type codes.
`define GLA_TYPE_NONE      2'h0
`define GLA_TYPE_HIGH      2'h1
`define GLA_TYPE_LOW       2'h2

// Clearing policy codes.
`define GLA_CLR_AUTO       1'h0
`define GLA_CLR_MANUAL     1'h1

// Trouble policy codes.
`define GLA_TRB_HOLD       2'h0
`define GLA_TRB_SET        2'h1
`define GLA_TRB_RESET      2'h2

// Timing in seconds (inhibit also in minutes), and clock rate.
`define GLA_CLK_HZ         100000000
`define GLA_TRIP_DLY_MAX_S 10
`define GLA_CLR_DLY_MAX_S  7200
`define GLA_INHIBIT_MIN    15
`define GLA_INHIBIT_S      (`GLA_INHIBIT_MIN * 60)

// Default thresholds, tenths of a percent.
`define GLA_TOX_A1_TRIP    16'h0064
`define GLA_TOX_A2_TRIP    16'h0032
`define GLA_TOX_A3_TRIP    16'hFF9C
`define GLA_TOX_TROUBLE    16'hFF38
`define GLA_O2_A1_TRIP     16'h00A0
`define GLA_O2_A2_TRIP     16'h00C3
`define GLA_O2_A3_TRIP     16'h00E6

// Indicator identity letters in ASCII.
`define GLA_ID_A           8'h41
`define GLA_ID_W           8'h57
`define GLA_ID_C           8'h43

`endif

//--- gla_evaluator.v
/*
 * Gas level alarm evaluator: three configurable level alarms with trip and
 * clear thresholds, second-based delays, auto or manual clearing, trouble
 * policy, timed inhibit and event timestamps.
 * Assumes a synchronous one-cycle tick once per second, a reading sampled
 * on that tick, and threshold limits supplied from the sensor store.
 */
`timescale 1ns/1ns
`include "gla_defs.vh"

module gla_evaluator (
    // Clock and reset.
    input  wire        clk,
    input  wire        rst,
    // Timing and reading.
    input  wire        sec_tick,
    input  wire [15:0] reading,
    input  wire [31:0] date_time,
    // Sensor store: kind, alarm types and trip limits.
    input  wire        sensor_is_oxygen,
    input  wire        load_defaults,
    input  wire [5:0]  store_type,
    input  wire [15:0] trip_limit_min,
    input  wire [15:0] trip_limit_max,
    // Configuration writes for one selected alarm.
    input  wire [1:0]  cfg_sel,
    input  wire        cfg_trip_we,
    input  wire [15:0] cfg_trip,
    input  wire        cfg_clear_we,
    input  wire [15:0] cfg_clear,
    input  wire        cfg_delay_we,
    input  wire [3:0]  cfg_trip_dly,
    input  wire [12:0] cfg_clear_dly,
    input  wire        cfg_policy_we,
    input  wire        cfg_manual,
    input  wire [1:0]  cfg_trouble_pol,
    // Operator commands.
    input  wire        clear_one,
    input  wire [1:0]  clear_sel,
    input  wire        clear_all,
    input  wire        ext_clear,
    input  wire        inhibit_cmd,
    input  wire        fault_in,
    // Status.
    output reg  [2:0]  alarm_active,
    output reg         any_active,
    output reg         trouble,
    output reg         inhibit_active,
    output reg  [26:0] indicator,
    output reg  [95:0] event_time
);

    localparam [9:0]  INHIBIT_S   = `GLA_INHIBIT_S;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration store.

    reg  [15:0] trip_thr  [0:2];
    reg  [15:0] clear_thr [0:2];
    reg  [3:0]  trip_dly  [0:2];
    reg  [12:0] clear_dly [0:2];
    reg         manual    [0:2];
    reg  [1:0]  trb_pol   [0:2];
    reg  [9:0]  inh_cnt;

    wire signed [15:0] rd = reading;

    // Default trip thresholds by sensor kind.
    function [15:0] dflt_trip;
        input       oxy;
        input [1:0] idx;
        begin
            case (idx)
                2'h0:    dflt_trip = oxy ? `GLA_O2_A1_TRIP : `GLA_TOX_A1_TRIP;
                2'h1:    dflt_trip = oxy ? `GLA_O2_A2_TRIP : `GLA_TOX_A2_TRIP;
                default: dflt_trip = oxy ? `GLA_O2_A3_TRIP : `GLA_TOX_A3_TRIP;
            endcase
        end
    endfunction

    // Limits a clear threshold to its allowed band for the alarm type.
    function [15:0] clamp_clear;
        input [1:0]  typ;
        input [15:0] val;
        input [15:0] trip;
        input [15:0] lmin;
        input [15:0] lmax;
        begin
            clamp_clear = val;
            if (typ == `GLA_TYPE_HIGH) begin
                if ($signed(val) > $signed(trip))
                    clamp_clear = trip;
                else if ($signed(val) < $signed(lmin))
                    clamp_clear = lmin;
            end else if (typ == `GLA_TYPE_LOW) begin
                if ($signed(val) < $signed(trip))
                    clamp_clear = trip;
                else if ($signed(val) > $signed(lmax))
                    clamp_clear = lmax;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Per-alarm conditions.

    reg [2:0] trip_met;
    reg [2:0] clear_met;
    reg [1:0] typ [0:2];
    integer k;

    always @* begin
        for (k = 0; k < 3; k = k + 1) begin
            typ[k] = store_type[2*k +: 2];
            case (typ[k])
                `GLA_TYPE_HIGH: begin
                    trip_met[k]  = rd >= $signed(trip_thr[k]);
                    clear_met[k] = rd <  $signed(clear_thr[k]);
                end
                `GLA_TYPE_LOW: begin
                    trip_met[k]  = rd <= $signed(trip_thr[k]);
                    clear_met[k] = rd >  $signed(clear_thr[k]);
                end
                default: begin
                    trip_met[k]  = 1'b0;
                    clear_met[k] = 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Delay counters, one trip and one clear counter per alarm.

    wire [11:0] trip_cnt;
    wire [38:0] clear_cnt;
    genvar      g;

    generate
        for (g = 0; g < 3; g = g + 1) begin : dly
            gla_delay_cnt #(
                .WIDTH     (4)
            ) u_trip (
                .clk       (clk),
                .rst       (rst),
                .sec_tick  (sec_tick),
                .hold_zero (~trip_met[g] | alarm_active[g]),
                .limit     (trip_dly[g]),
                .count     (trip_cnt[4*g +: 4])
            );
            gla_delay_cnt #(
                .WIDTH     (13)
            ) u_clear (
                .clk       (clk),
                .rst       (rst),
                .sec_tick  (sec_tick),
                .hold_zero (~clear_met[g] | ~alarm_active[g]),
                .limit     (clear_dly[g]),
                .count     (clear_cnt[13*g +: 13])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Operator release requests, per alarm.

    wire [2:0] sel_clear;
    wire [2:0] release_req;

    assign sel_clear[0] = clear_one && (clear_sel == 2'h0);
    assign sel_clear[1] = clear_one && (clear_sel == 2'h1);
    assign sel_clear[2] = clear_one && (clear_sel == 2'h2);
    // A request only counts once the alarm's trip condition has gone.
    assign release_req  = (sel_clear | {3{clear_all}} | {3{ext_clear}}) & ~trip_met;

    ////////////////////////////////////////////////////////////////////////////
    // Inhibit timer, trouble flag and summary.

    wire trouble_cond = fault_in | (rd <= $signed(`GLA_TOX_TROUBLE));

    // Inhibit clears alarms and trouble at once, then counts down in seconds.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            inhibit_active <= 1'b0;
            inh_cnt        <= 10'h000;
            trouble        <= 1'b0;
            any_active     <= 1'b0;
        end else begin
            if (inhibit_cmd) begin
                inhibit_active <= 1'b1;
                inh_cnt        <= INHIBIT_S;
            end else if (inhibit_active && sec_tick) begin
                if (inh_cnt <= 10'h001)
                    inhibit_active <= 1'b0;
                inh_cnt <= inh_cnt - 10'h001;
            end
            trouble    <= trouble_cond & ~inhibit_active & ~inhibit_cmd;
            any_active <= |alarm_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration writes.

    integer j;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            for (j = 0; j < 3; j = j + 1) begin
                trip_thr[j]  <= 16'h0000;
                clear_thr[j] <= 16'h0000;
                trip_dly[j]  <= 4'h0;
                clear_dly[j] <= 13'h0000;
                manual[j]    <= `GLA_CLR_AUTO;
                trb_pol[j]   <= `GLA_TRB_HOLD;
            end
        end else begin
            for (j = 0; j < 3; j = j + 1) begin
                if (load_defaults) begin
                    trip_thr[j]  <= dflt_trip(sensor_is_oxygen, j[1:0]);
                    clear_thr[j] <= dflt_trip(sensor_is_oxygen, j[1:0]);
                end else if (cfg_trip_we && cfg_sel == j[1:0]) begin
                    trip_thr[j]  <= cfg_trip;
                    clear_thr[j] <= cfg_trip;
                end else if (cfg_clear_we && cfg_sel == j[1:0]) begin
                    clear_thr[j] <= clamp_clear(typ[j], cfg_clear, trip_thr[j],
                                                trip_limit_min, trip_limit_max);
                end
                if (cfg_delay_we && cfg_sel == j[1:0]) begin
                    trip_dly[j]  <= (cfg_trip_dly > `GLA_TRIP_DLY_MAX_S) ? 4'hA : cfg_trip_dly;
                    clear_dly[j] <= (cfg_clear_dly > `GLA_CLR_DLY_MAX_S) ? 13'h1C20 : cfg_clear_dly;
                end
                if (cfg_policy_we && cfg_sel == j[1:0]) begin
                    manual[j]  <= cfg_manual;
                    trb_pol[j] <= cfg_trouble_pol;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alarm state machine.

    integer i;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            alarm_active <= 3'h0;
            event_time   <= 96'h0;
        end else begin
            for (i = 0; i < 3; i = i + 1) begin
                if (typ[i] == `GLA_TYPE_NONE || inhibit_cmd || inhibit_active) begin
                    alarm_active[i] <= 1'b0;
                end else if (trouble) begin
                    if (trb_pol[i] == `GLA_TRB_SET && !alarm_active[i]) begin
                        alarm_active[i]      <= 1'b1;
                        event_time[32*i+:32] <= date_time;
                    end else if (trb_pol[i] == `GLA_TRB_RESET)
                        alarm_active[i] <= 1'b0;
                end else if (!alarm_active[i]) begin
                    if (sec_tick && trip_met[i] && trip_cnt[4*i +: 4] >= trip_dly[i]) begin
                        alarm_active[i]      <= 1'b1;
                        event_time[32*i+:32] <= date_time;
                    end
                end else if (manual[i] == `GLA_CLR_MANUAL) begin
                    if (release_req[i])
                        alarm_active[i] <= 1'b0;
                end else if (sec_tick && clear_met[i] && clear_cnt[13*i +: 13] >= clear_dly[i]) begin
                    alarm_active[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alarm indicators.

    // Identity letter plus one sense bit, high for a rising alarm.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            indicator <= 27'h0000000;
        end else begin
            indicator <= {`GLA_ID_C, typ[2] == `GLA_TYPE_HIGH,
                          `GLA_ID_W, typ[1] == `GLA_TYPE_HIGH,
                          `GLA_ID_A, typ[0] == `GLA_TYPE_HIGH};
        end
    end

endmodule

////////////////////////////////////////////////////////////////////////////////
// Seconds counter shared by trip and clear delays. It restarts whenever its
// condition fails on a tick and stops at the programmed delay, so the compare
// against the delay stays true for as long as the condition lasts.
module gla_delay_cnt #(
    parameter WIDTH = 4
) (
    // Clock and reset.
    input  wire             clk,
    input  wire             rst,
    // Count control.
    input  wire             sec_tick,
    input  wire             hold_zero,
    input  wire [WIDTH-1:0] limit,
    // Count value.
    output reg  [WIDTH-1:0] count
);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= {WIDTH{1'b0}};
        end else if (sec_tick) begin
            if (hold_zero)
                count <= {WIDTH{1'b0}};
            else if (count < limit)
                count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

//--- gla_evaluator_properties.sv
/* Concurrent checks on the ports of the gas level alarm evaluator.
   Assumes one clock domain with an asynchronous active-high reset. */
`timescale 1ns/1ns
`include "gla_defs.vh"
module gla_properties (
    // Clock and reset.
    input wire        clk,
    input wire        rst,
    // Inputs watched.
    input wire        sec_tick,
    input wire [15:0] reading,
    input wire [31:0] date_time,
    input wire [5:0]  store_type,
    input wire        inhibit_cmd,
    input wire        fault_in,
    // Outputs watched.
    input wire [2:0]  alarm_active,
    input wire        any_active,
    input wire        trouble,
    input wire        inhibit_active,
    input wire [26:0] indicator,
    input wire [95:0] event_time
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_summary_flag: assert property (any_active == |$past(alarm_active))
        else $error("summary flag wrong");
    a_set_on_tick: assert property ($rose(alarm_active[0]) && !$past(trouble) |-> $past(sec_tick))
        else $error("alarm set without tick");
    a_capture_time: assert property ($rose(alarm_active[0]) |-> event_time[31:0] == $past(date_time))
        else $error("event time not captured");
    a_time_held: assert property (!$rose(alarm_active[0]) |-> $stable(event_time[31:0]))
        else $error("event time changed");
    a_none_quiet: assert property (store_type[3:2] == `GLA_TYPE_NONE
        && $past(store_type[3:2]) == `GLA_TYPE_NONE |-> !alarm_active[1])
        else $error("type none alarm active");
    a_inhibit_start: assert property (inhibit_cmd |=> inhibit_active && alarm_active == 3'h0)
        else $error("inhibit did not clear");
    a_inhibit_quiet: assert property (inhibit_active && $past(inhibit_active) |-> alarm_active == 3'h0 && !trouble)
        else $error("alarm during inhibit");
    a_trouble_drift: assert property ($signed(reading) <= -200 && !inhibit_active && !inhibit_cmd |=> trouble)
        else $error("trouble missing");
    a_trouble_free: assert property (!fault_in && $signed(reading) > -200 |=> !trouble)
        else $error("trouble without cause");
    a_indicator_ids: assert property (!$past(rst) |-> indicator[8:1] == `GLA_ID_A
        && indicator[17:10] == `GLA_ID_W && indicator[26:19] == `GLA_ID_C)
        else $error("indicator letters wrong");
    c_alarm_set: cover property ($rose(alarm_active[0]));
    c_manual_clear: cover property ($fell(alarm_active[2]));
    c_inhibit: cover property ($rose(inhibit_active));
endmodule
bind gla_evaluator gla_properties u_props (.clk, .rst, .sec_tick, .reading, .date_time, .store_type, .inhibit_cmd,
    .fault_in, .alarm_active, .any_active, .trouble, .inhibit_active, .indicator, .event_time);

//--- tb_top.sv
/* Self-checking bench for the gas level alarm evaluator.
   Assumes inputs are driven on falling edges and one tick every few cycles. */
`timescale 1ns/1ns
`include "gla_defs.vh"
module tb_top;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         sec_tick, sensor_is_oxygen, load_defaults, fault_in, cfg_manual;
    reg         cfg_trip_we, cfg_clear_we, cfg_delay_we, cfg_policy_we;
    reg         clear_one, clear_all, ext_clear, inhibit_cmd;
    reg  [1:0]  cfg_sel, clear_sel, cfg_trouble_pol;
    reg  [3:0]  cfg_trip_dly;
    reg  [5:0]  store_type;
    reg  [12:0] cfg_clear_dly;
    reg  [15:0] reading, trip_limit_min, trip_limit_max, cfg_trip, cfg_clear;
    reg  [31:0] date_time;
    wire [2:0]  alarm_active;
    wire        any_active, trouble, inhibit_active;
    wire [26:0] indicator;
    wire [95:0] event_time;
    integer     n_fail = 0;
    integer     checks_done = 0;
    integer     k;
    gla_evaluator DUT (.clk, .rst, .sec_tick, .reading, .date_time, .sensor_is_oxygen, .load_defaults,
        .store_type, .trip_limit_min, .trip_limit_max, .cfg_sel, .cfg_trip_we, .cfg_trip, .cfg_clear_we,
        .cfg_clear, .cfg_delay_we, .cfg_trip_dly, .cfg_clear_dly, .cfg_policy_we, .cfg_manual,
        .cfg_trouble_pol, .clear_one, .clear_sel, .clear_all, .ext_clear, .inhibit_cmd, .fault_in,
        .alarm_active, .any_active, .trouble, .inhibit_active, .indicator, .event_time);
    initial forever #5 clk = ~clk;
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        checks_done = checks_done + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tick;
        sec_tick = 1'b1;
        @(negedge clk);
        sec_tick = 1'b0;
        @(negedge clk);
    endtask
    task cfg(input [1:0] s, input [15:0] t, input [3:0] d, input [12:0] cd, input m);
        {cfg_sel, cfg_trip, cfg_trip_dly, cfg_clear_dly, cfg_manual} = {s, t, d, cd, m};
        {cfg_trip_we, cfg_delay_we, cfg_policy_we} = 3'h7;
        @(negedge clk);
        {cfg_trip_we, cfg_delay_we, cfg_policy_we} = 3'h0;
    endtask
    // Kind 0 clears one selected alarm, 1 clears all, 2 is the external clear.
    task cmd(input integer c);
        clear_sel = 2'h2;
        {clear_one, clear_all, ext_clear} = {c == 0, c == 1, c == 2};
        @(negedge clk);
        {clear_one, clear_all, ext_clear} = 3'h0;
        @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {sec_tick, sensor_is_oxygen, load_defaults, fault_in, cfg_manual, cfg_trip_we} = 6'h00;
        {cfg_clear_we, cfg_delay_we, cfg_policy_we, clear_one, clear_all, ext_clear, inhibit_cmd} = 7'h00;
        {cfg_sel, clear_sel, cfg_trouble_pol, cfg_trip_dly, cfg_clear_dly} = 23'h000000;
        {cfg_trip, cfg_clear, reading, date_time} = 80'h0;
        store_type = 6'h25;
        trip_limit_min = 16'hFF00;
        trip_limit_max = 16'h0300;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("indicator", {`GLA_ID_C, 1'b0, `GLA_ID_W, 1'b1, `GLA_ID_A, 1'b1}, indicator);
        store_type = 6'h21;
        cfg(2'h0, 16'h0064, 4'h2, 13'h0001, `GLA_CLR_AUTO);
        cfg(2'h2, 16'hFFCE, 4'h0, 13'h0000, `GLA_CLR_MANUAL);
        reading = 16'h0064;
        tick;
        reading = 16'h0063;
        tick;
        reading = 16'h0064;
        date_time = 32'h00000A01;
        repeat (2) tick;
        chk("alarm early", 3'h0, alarm_active);
        tick;
        chk("alarm set", 3'h1, alarm_active);
        chk("event time", 32'h00000A01, event_time[31:0]);
        chk("summary", 1'b1, any_active);
        reading = 16'h0063;
        tick;
        chk("clear wait", 3'h1, alarm_active);
        tick;
        chk("auto clear", 3'h0, alarm_active);
        cfg_sel = 2'h0;
        cfg_clear = 16'h00C8;
        cfg_clear_we = 1'b1;
        @(negedge clk);
        cfg_clear_we = 1'b0;
        reading = 16'h0096;
        repeat (5) tick;
        chk("clear clamp", 3'h1, alarm_active);
        $display("test high alarm done");
        for (k = 0; k < 3; k = k + 1) begin
            reading = 16'hFFCE;
            tick;
            chk("low set", 3'h4, alarm_active & 3'h4);
            cmd(k);
            chk("clear in condition", 3'h4, alarm_active & 3'h4);
            reading = 16'h0000;
            tick;
            chk("latched", 3'h4, alarm_active & 3'h4);
            cmd(k);
            chk("released", 3'h0, alarm_active & 3'h4);
        end
        $display("test manual clear done");
        reading = 16'h0064;
        repeat (3) tick;
        reading = 16'hFF38;
        @(negedge clk);
        repeat (2) tick;
        chk("trouble", 1'b1, trouble);
        chk("hold", 3'h1, alarm_active);
        inhibit_cmd = 1'b1;
        @(negedge clk);
        inhibit_cmd = 1'b0;
        @(negedge clk);
        chk("inhibit start", 32'h10, {inhibit_active, alarm_active, trouble});
        reading = 16'h0064;
        repeat (895) tick;
        chk("inhibited", 32'h10, {inhibit_active, alarm_active, trouble});
        repeat (10) tick;
        chk("inhibit end", 32'h02, {inhibit_active, alarm_active, trouble});
        fault_in = 1'b1;
        repeat (2) @(negedge clk);
        chk("fault trouble", 1'b1, trouble);
        cfg_sel = 2'h0;
        cfg_manual = `GLA_CLR_AUTO;
        for (k = 2; k > 0; k = k - 1) begin
            cfg_trouble_pol = k[1:0];
            cfg_policy_we = 1'b1;
            @(negedge clk);
            cfg_policy_we = 1'b0;
            @(negedge clk);
            chk("trouble policy", k[0], alarm_active & 3'h1);
        end
        fault_in = 1'b0;
        $display("test trouble and inhibit done");
        load_defaults = 1'b1;
        @(negedge clk);
        load_defaults = 1'b0;
        reading = 16'hFF9D;
        @(negedge clk);
        tick;
        chk("toxic above", 3'h0, alarm_active & 3'h4);
        reading = 16'hFF9C;
        tick;
        chk("toxic caution", 3'h4, alarm_active & 3'h4);
        sensor_is_oxygen = 1'b1;
        store_type = 6'h12;
        load_defaults = 1'b1;
        @(negedge clk);
        load_defaults = 1'b0;
        reading = 16'h00A1;
        repeat (3) tick;
        chk("oxygen above", 3'h0, alarm_active & 3'h1);
        reading = 16'h00A0;
        repeat (3) tick;
        chk("oxygen low", 3'h1, alarm_active & 3'h1);
        $display("test defaults done");
        end_of_test;
    end
    initial begin
        #200000;
        n_fail = n_fail + 1;
        end_of_test;
    end
endmodule
